// >>> verilog/adcr_defs.svh
`ifndef ADCR_DEFS_SVH
`define ADCR_DEFS_SVH

`define ADCR_WORD_W        24
`define ADCR_CODE_W        22
`define ADCR_RAW_W         23
`define ADCR_BIT_OVL       23
`define ADCR_BIT_OVH       22
`define ADCR_BIT_SIGN      21
`define ADCR_POS_FULL      23'h1fffff
`define ADCR_NEG_FULL      23'h600000
`define ADCR_LAST_BIT      5'h18
`define ADCR_CNT_W         5
`define ADCR_CLK_PERIOD_NS 25
`define ADCR_OSC_PERIOD_NS 9766
`define ADCR_OSC_DIV       ((`ADCR_OSC_PERIOD_NS + `ADCR_CLK_PERIOD_NS - 1) / `ADCR_CLK_PERIOD_NS)
`define ADCR_DIV_W         9
`define ADCR_PER_W         16
`define ADCR_SETTLE_OSC    16'h0020
`define ADCR_CONV_OSC      16'h2000

`endif

// >>> verilog/adcr_pkg.sv
`default_nettype none
package adcr_pkg;
   // Result word as shifted out, bit 23 first
   typedef struct packed {
      logic        overflow_low_flag;
      logic        overflow_high_flag;
      logic [21:0] code;
   } adcr_word_t;

   typedef enum logic [3:0] {
      ST_SHUTDOWN = 4'h1,
      ST_SETTLE   = 4'h2,
      ST_CONVERT  = 4'h4,
      ST_SLEEP    = 4'h8
   } adcr_state_t;
endpackage
`default_nettype wire

// >>> verilog/adcr_sync.sv
`default_nettype none
module adcr_sync #(
   parameter int W = 2
) (
   input  wire logic         i_clock,
   input  wire logic         i_rst_n,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   // Two flops per bit; only the second flop reads the first
   generate
      for (genvar g = 0; g < W; g++) begin : g_bit
         logic meta_q;
         logic sync_q;
         always_ff @(posedge i_clock or negedge i_rst_n) begin
            if (!i_rst_n) begin
               meta_q <= 1'b1;
               sync_q <= 1'b1;
            end else begin
               meta_q <= i_async[g];
               sync_q <= meta_q;
            end
         end
         assign o_sync[g] = sync_q;
      end
   endgenerate
endmodule // adcr_sync
`default_nettype wire

// >>> verilog/adcr_osc_timer.sv
`include "adcr_defs.svh"
`default_nettype none
module adcr_osc_timer #(
   parameter logic [`ADCR_DIV_W-1:0] OSC_DIV = `ADCR_DIV_W'(`ADCR_OSC_DIV)
) (
   input  wire logic                   i_clock,
   input  wire logic                   i_rst_n,
   input  wire logic                   i_run,
   input  wire logic                   i_start,
   input  wire logic [`ADCR_PER_W-1:0] i_target,
   output logic                        o_done
);
   logic [`ADCR_DIV_W-1:0] div_q;
   logic [`ADCR_PER_W-1:0] per_q;
   logic                   tick;

   // Internal oscillator period derived from the system clock
   assign tick   = i_run && (div_q == OSC_DIV - `ADCR_DIV_W'(1));
   assign o_done = tick && (per_q == i_target - `ADCR_PER_W'(1));

   // Oscillator is held in reset while not running
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_q <= '0;
      end else if (!i_run || i_start || tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + `ADCR_DIV_W'(1);
      end
   end

   // Period counter wraps so back-to-back intervals need no restart
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         per_q <= '0;
      end else if (!i_run || i_start || o_done) begin
         per_q <= '0;
      end else if (tick) begin
         per_q <= per_q + `ADCR_PER_W'(1);
      end
   end
endmodule // adcr_osc_timer
`default_nettype wire

// >>> verilog/adcr_top.sv
`include "adcr_defs.svh"
`default_nettype none
module adcr_top #(
   parameter logic [`ADCR_PER_W-1:0] SETTLE_OSC = `ADCR_SETTLE_OSC,
   parameter logic [`ADCR_PER_W-1:0] CONV_OSC   = `ADCR_CONV_OSC,
   parameter logic [`ADCR_DIV_W-1:0] OSC_DIV    = `ADCR_DIV_W'(`ADCR_OSC_DIV)
) (
   input  wire logic                  i_clock,
   input  wire logic                  i_arst_n,
   input  wire logic                  i_chip_select_low_active_n,
   input  wire logic                  i_serial_clock,
   input  wire logic [`ADCR_RAW_W-1:0] i_filter_value,
   output logic                       o_data_out_ready_pin,
   output logic                       o_data_out_ready_pin_oe,
   output logic                       o_modulator_run,
   output logic                       o_result_load,
   output logic                       o_shutdown,
   output logic                       o_single_mode,
   output adcr_pkg::adcr_word_t       o_result_word
);
   logic                   rst_q1;
   logic                   rst_q2;
   logic [1:0]             pins_s;
   logic                   cs_s;
   logic                   sck_s;
   logic                   cs_prev_q;
   logic                   sck_prev_q;
   logic                   cs_fall;
   logic                   cs_rise;
   logic                   sck_fall;
   adcr_pkg::adcr_state_t  state_q;
   adcr_pkg::adcr_state_t  state_d;
   logic                   timer_done;
   logic                   timer_start;
   logic                   timer_run;
   logic [`ADCR_PER_W-1:0] timer_target;
   logic                   conv_end;
   logic                   single_q;
   adcr_pkg::adcr_word_t   new_word;
   adcr_pkg::adcr_word_t   out_q;
   adcr_pkg::adcr_word_t   pend_q;
   logic                   pend_valid_q;
   logic                   avail_q;
   logic [`ADCR_CNT_W-1:0] bit_cnt_q;
   logic                   reading;
   logic                   read_done;
   logic                   rdy_latch_q;
   logic                   ready_level;
   logic                   pin_d;
   logic                   pin_q;
   logic                   oe_q;
   logic                   load_q;
   logic                   shut_entry;

   // Reset release through two flops
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_q1 <= 1'b0;
         rst_q2 <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_q2 <= rst_q1;
      end
   end

   // Pins from the host are asynchronous to the block clock
   adcr_sync #(
      .W (2)
   ) u_sync (
      .i_clock (i_clock),
      .i_rst_n (rst_q2),
      .i_async ({i_serial_clock, i_chip_select_low_active_n}),
      .o_sync  (pins_s)
   );
   assign cs_s  = pins_s[0];
   assign sck_s = pins_s[1];

   // Edge detection on the synchronised pins
   always_ff @(posedge i_clock or negedge rst_q2) begin
      if (!rst_q2) begin
         cs_prev_q  <= 1'b1;
         sck_prev_q <= 1'b1;
      end else begin
         cs_prev_q  <= cs_s;
         sck_prev_q <= sck_s;
      end
   end
   assign cs_fall  = cs_prev_q && !cs_s;
   assign cs_rise  = !cs_prev_q && cs_s;
   assign sck_fall = sck_prev_q && !sck_s && !cs_s;

   // Settle and conversion interval timer on the internal oscillator
   assign timer_run    = (state_q == adcr_pkg::ST_SETTLE) || (state_q == adcr_pkg::ST_CONVERT);
   assign timer_start  = (state_d != state_q);
   assign timer_target = (state_q == adcr_pkg::ST_SETTLE) ? SETTLE_OSC : CONV_OSC;
   adcr_osc_timer #(
      .OSC_DIV (OSC_DIV)
   ) u_timer (
      .i_clock  (i_clock),
      .i_rst_n  (rst_q2),
      .i_run    (timer_run),
      .i_start  (timer_start),
      .i_target (timer_target),
      .o_done   (timer_done)
   );
   // Every conversion end captures a result, also the one that enters sleep
   assign conv_end = (state_q == adcr_pkg::ST_CONVERT) && timer_done;

   // Next operating state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         adcr_pkg::ST_SHUTDOWN: begin
            if (cs_fall) begin
               state_d = adcr_pkg::ST_SETTLE;
            end
         end
         adcr_pkg::ST_SETTLE: begin
            if (timer_done) begin
               state_d = cs_s && single_q ? adcr_pkg::ST_SHUTDOWN : adcr_pkg::ST_CONVERT;
            end
         end
         adcr_pkg::ST_CONVERT: begin
            if (timer_done) begin
               if (single_q || cs_rise) begin
                  state_d = cs_s ? adcr_pkg::ST_SLEEP : adcr_pkg::ST_SLEEP;
               end
            end
         end
         adcr_pkg::ST_SLEEP: begin
            if (cs_rise) begin
               state_d = adcr_pkg::ST_SHUTDOWN;
            end
         end
      endcase
   end

   // State register; power-up begins with the settle interval
   always_ff @(posedge i_clock or negedge rst_q2) begin
      if (!rst_q2) begin
         state_q <= adcr_pkg::ST_SETTLE;
      end else begin
         state_q <= state_d;
      end
   end
   assign shut_entry = (state_q != adcr_pkg::ST_SHUTDOWN) && (state_d == adcr_pkg::ST_SHUTDOWN);

   // Conversion mode: rising chip select while running selects single
   always_ff @(posedge i_clock or negedge rst_q2) begin
      if (!rst_q2) begin
         single_q <= 1'b0;
      end else if (state_q == adcr_pkg::ST_SHUTDOWN && cs_fall) begin
         single_q <= 1'b0;
      end else if (timer_run && cs_rise) begin
         single_q <= 1'b1;
      end
   end

   // Result word from the settled filter value, never clamped
   always_comb begin
      new_word      = '0;
      new_word.overflow_high_flag  = $signed(i_filter_value) > $signed(`ADCR_POS_FULL);
      new_word.overflow_low_flag  = $signed(i_filter_value) < $signed(`ADCR_NEG_FULL);
      new_word.code = i_filter_value[`ADCR_CODE_W-1:0];
   end

   // Readout progress: count of serial clock falls seen
   assign reading   = (bit_cnt_q != '0);
   assign read_done = sck_fall && (bit_cnt_q == `ADCR_LAST_BIT);

   // Output register: a result ending with the last bit goes straight in
   always_ff @(posedge i_clock or negedge rst_q2) begin
      if (!rst_q2) begin
         out_q <= '0;
      end else if (conv_end && (!reading || read_done)) begin
         out_q <= new_word;
      end else if (read_done && pend_valid_q) begin
         out_q <= pend_q;
      end
   end

   // Newest result held back while a word is being shifted out
   always_ff @(posedge i_clock or negedge rst_q2) begin
      if (!rst_q2) begin
         pend_q <= '0;
      end else if (conv_end && reading && !read_done) begin
         pend_q <= new_word;
      end
   end

   // Pending flag; a direct load makes an older pending word stale
   always_ff @(posedge i_clock or negedge rst_q2) begin
      if (!rst_q2) begin
         pend_valid_q <= 1'b0;
      end else if (shut_entry) begin
         pend_valid_q <= 1'b0;
      end else if (conv_end && reading && !read_done) begin
         pend_valid_q <= 1'b1;
      end else if (conv_end || read_done) begin
         pend_valid_q <= 1'b0;
      end
   end

   // Data-available flag; a new result wins over a finished word
   always_ff @(posedge i_clock or negedge rst_q2) begin
      if (!rst_q2) begin
         avail_q <= 1'b0;
      end else if (shut_entry) begin
         avail_q <= 1'b0;
      end else if (conv_end) begin
         avail_q <= 1'b1;
      end else if (read_done && !pend_valid_q) begin
         avail_q <= 1'b0;
      end
   end

   // Ready level latched at each chip select fall for single mode
   always_ff @(posedge i_clock or negedge rst_q2) begin
      if (!rst_q2) begin
         rdy_latch_q <= 1'b1;
      end else if (cs_fall) begin
         rdy_latch_q <= !avail_q;
      end else if (read_done) begin
         rdy_latch_q <= 1'b1;
      end
   end
   assign ready_level = single_q ? rdy_latch_q : !avail_q;

   // Serial clock fall counter; a raised chip select aborts the word
   always_ff @(posedge i_clock or negedge rst_q2) begin
      if (!rst_q2) begin
         bit_cnt_q <= '0;
      end else if (cs_s || shut_entry) begin
         bit_cnt_q <= '0;
      end else if (read_done) begin
         bit_cnt_q <= '0;
      end else if (sck_fall && (reading || !ready_level)) begin
         bit_cnt_q <= bit_cnt_q + `ADCR_CNT_W'(1);
      end
   end

   // Pin shows a data bit while reading, else the ready level
   always_comb begin
      pin_d = ready_level;
      if (reading) begin
         pin_d = out_q[`ADCR_CNT_W'(`ADCR_LAST_BIT - bit_cnt_q)];
      end
   end

   // Registered pin drive and release
   always_ff @(posedge i_clock or negedge rst_q2) begin
      if (!rst_q2) begin
         pin_q <= 1'b1;
         oe_q  <= 1'b0;
      end else begin
         pin_q <= pin_d;
         oe_q  <= !cs_s;
      end
   end

   // One-cycle strobe when a new result is captured
   always_ff @(posedge i_clock or negedge rst_q2) begin
      if (!rst_q2) begin
         load_q <= 1'b0;
      end else begin
         load_q <= conv_end;
      end
   end

   assign o_data_out_ready_pin    = pin_q;
   assign o_data_out_ready_pin_oe = oe_q;
   assign o_modulator_run         = (state_q == adcr_pkg::ST_CONVERT);
   assign o_result_load           = load_q;
   assign o_shutdown              = (state_q == adcr_pkg::ST_SHUTDOWN);
   assign o_single_mode           = single_q;
   assign o_result_word           = out_q;
endmodule // adcr_top
`default_nettype wire

// >>> dv/adcr_checker.sv
`include "adcr_defs.svh"
`default_nettype none
module adcr_checker #(
   parameter logic [`ADCR_PER_W-1:0] SETTLE_OSC = `ADCR_SETTLE_OSC,
   parameter logic [`ADCR_PER_W-1:0] CONV_OSC   = `ADCR_CONV_OSC,
   parameter logic [`ADCR_DIV_W-1:0] OSC_DIV    = `ADCR_DIV_W'(`ADCR_OSC_DIV)
) (
   input wire logic                    i_clock,
   input wire logic                    i_arst_n,
   input wire logic                    i_chip_select_low_active_n,
   input wire logic [`ADCR_RAW_W-1:0]  i_filter_value,
   input wire logic                    o_data_out_ready_pin_oe,
   input wire logic                    o_modulator_run,
   input wire logic                    o_result_load,
   input wire logic                    o_shutdown,
   input wire logic                    o_single_mode,
   input wire adcr_pkg::adcr_word_t    o_result_word
);
   localparam int SET_CYC = int'(SETTLE_OSC) * int'(OSC_DIV);
   int                     gap_q;
   logic [`ADCR_RAW_W-1:0] fv_q;
   // Idle cycles since the last shutdown, conversion or reset
   always_ff @(posedge i_clock or negedge i_arst_n)
      if (!i_arst_n) gap_q <= 0;
      else if (o_shutdown || o_modulator_run) gap_q <= 0;
      else gap_q <= gap_q + 1;
   // Filter value one cycle back
   always_ff @(posedge i_clock)
      fv_q <= i_filter_value;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_arst_n);
   oe_release_a: assert property (i_chip_select_low_active_n [*6] |-> !o_data_out_ready_pin_oe)
      else $error("pin driven while deselected");
   oe_drive_a: assert property (!i_chip_select_low_active_n [*8] |-> o_data_out_ready_pin_oe)
      else $error("pin not driven while selected");
   load_after_run_a: assert property ($rose(o_result_load) |-> $past(o_modulator_run))
      else $error("load without conversion");
   sleep_single_a: assert property (o_result_load && o_single_mode |-> !o_modulator_run && !o_shutdown)
      else $error("single end did not sleep");
   cont_restart_a: assert property (o_result_load && !o_single_mode |-> o_modulator_run or ##1 o_single_mode)
      else $error("continuous mode did not restart");
   word_code_a: assert property (o_result_load && o_single_mode |-> o_result_word.code == fv_q[21:0])
      else $error("code field wrong");
   word_flags_a: assert property (o_result_load && o_single_mode |->
      o_result_word.overflow_high_flag == (!fv_q[22] && fv_q[21]) && o_result_word.overflow_low_flag == (fv_q[22] && !fv_q[21]))
      else $error("overflow flags wrong");
   wake_start_a: assert property (o_shutdown && $fell(i_chip_select_low_active_n) |-> ##[1:6] !o_shutdown)
      else $error("no wake from shutdown");
   settle_gap_a: assert property ($rose(o_modulator_run) |-> gap_q >= SET_CYC - 1 && gap_q <= SET_CYC + 6)
      else $error("settle interval wrong");
   sleep_load_a: assert property ($fell(o_modulator_run) |-> o_result_load)
      else $error("conversion ended without load");
   cover property (o_result_load && o_single_mode);
   cover property (o_result_load && !o_single_mode);
   cover property ($rose(o_shutdown));
endmodule // adcr_checker

bind adcr_top adcr_checker #(.SETTLE_OSC(SETTLE_OSC), .CONV_OSC(CONV_OSC), .OSC_DIV(OSC_DIV)) chk_u (
   .i_clock(i_clock), .i_arst_n(i_arst_n), .i_chip_select_low_active_n(i_chip_select_low_active_n),
   .i_filter_value(i_filter_value), .o_data_out_ready_pin_oe(o_data_out_ready_pin_oe),
   .o_modulator_run(o_modulator_run), .o_result_load(o_result_load), .o_shutdown(o_shutdown),
   .o_single_mode(o_single_mode), .o_result_word(o_result_word));
`default_nettype wire

// >>> dv/adcr_host_model.sv
`default_nettype none
module adcr_host_model (
   input  wire logic i_clock,
   input  wire logic i_pin,
   input  wire logic i_pin_oe,
   output logic      o_cs_n,
   output logic      o_sck
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last_q;
   logic line;
   // Released line floats: show the inverse of the last driven level
   always_ff @(posedge i_clock)
      if (i_pin_oe) last_q <= i_pin;
   assign line = i_pin_oe ? i_pin : ~last_q;
   initial begin
      o_cs_n = 1'b1;
      o_sck = 1'b1;
   end
   // Wait whole cycles, ending on a falling edge
   task automatic idle(input int n);
      repeat (n) @(negedge i_clock);
   endtask
   task automatic set_cs(input logic v);
      @(negedge i_clock);
      o_cs_n = v;
   endtask
   // One 200 ns serial clock, sampled just before the next fall
   task automatic pulse(output logic b);
      o_sck = 1'b0;
      idle(4);
      o_sck = 1'b1;
      idle(4);
      b = line;
   endtask
   // Word shift with chip select held low, then the 25th fall
   task automatic read_word(output logic [23:0] w, output logic tail, output logic err);
      for (int k = 23; k >= 0; k--) pulse(w[k]);
      pulse(tail);
      err = w[23] & w[22];
   endtask
endmodule // adcr_host_model
`default_nettype wire

// >>> dv/adcr_tb_top.sv
`default_nettype none
module adcr_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic                 clk, arst_n, cs_n, sck, pin, oe, run, load, shut, single, tail, err;
   logic [22:0]          fval;
   logic [23:0]          got;
   adcr_pkg::adcr_word_t word;
   int                   seed = 32'h20c7;
   int                   miscompares = 0;
   int                   n_tests = 0;
   logic [22:0]          corner [6] = '{23'h1fffff, 23'h200000, 23'h600000, 23'h5fffff, 23'h000001, 23'h7fffff};

   adcr_top #(.SETTLE_OSC(16'h0002), .CONV_OSC(16'h0008), .OSC_DIV(9'h002)) dut_u (
      .i_clock(clk), .i_arst_n(arst_n), .i_chip_select_low_active_n(cs_n), .i_serial_clock(sck),
      .i_filter_value(fval), .o_data_out_ready_pin(pin), .o_data_out_ready_pin_oe(oe), .o_modulator_run(run),
      .o_result_load(load), .o_shutdown(shut), .o_single_mode(single), .o_result_word(word));
   adcr_host_model host_u (.i_clock(clk), .i_pin(pin), .i_pin_oe(oe), .o_cs_n(cs_n), .o_sck(sck));

   // Word expected for a filter value
   function automatic logic [23:0] fmt(input logic [22:0] v);
      return {v[22] & ~v[21], ~v[22] & v[21], v[21:0]};
   endfunction
   task automatic check_val(input string n, input logic [23:0] e, input logic [23:0] g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic summarize();
      if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Host waits carry 0..3 random extra cycles to vary link timing
   task automatic wait_cyc(input int n);
      int extra;
      extra = $random(seed) & 3;
      host_u.idle(n + extra);
   endtask
   task automatic drive_cs(input logic v);
      host_u.set_cs(v);
   endtask
   // Clock and watchdog
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      summarize();
   end
   // Main sequence
   initial begin
      arst_n = 1'b0;
      fval = 23'h000000;
      repeat (8) @(negedge clk);
      arst_n = 1'b1;
      wait_cyc(60);
      check_val("oe_idle", 24'h0, 24'(oe));
      drive_cs(1'b0);
      // Continuous readout of corner and random codes
      for (int i = 0; i < 10; i++) begin
         fval = (i < 6) ? corner[i] : 23'($random(seed));
         wait_cyc(40);
         check_val("ready", 24'h0, 24'(pin));
         host_u.read_word(got, tail, err);
         check_val("word", fmt(fval), got);
      end
      // Newer results must not disturb a readout in progress
      fval = 23'h0a5a5a;
      wait_cyc(40);
      fork
         host_u.read_word(got, tail, err);
         begin
            wait_cyc(30);
            fval = 23'h03c3c3;
         end
      join
      check_val("word_held", fmt(23'h0a5a5a), got);
      host_u.read_word(got, tail, err);
      check_val("word_newest", fmt(23'h03c3c3), got);
      // Single conversion, then readout in sleep
      fval = corner[1];
      drive_cs(1'b1);
      wait_cyc(60);
      check_val("sleep", 24'h0, 24'({run, shut}));
      drive_cs(1'b0);
      wait_cyc(8);
      check_val("ready_single", 24'h0, 24'(pin));
      host_u.read_word(got, tail, err);
      check_val("word_single", fmt(corner[1]), got);
      check_val("tail_single", 24'h1, 24'(tail));
      check_val("flag_error", 24'h0, 24'(err));
      drive_cs(1'b1);
      wait_cyc(8);
      check_val("shutdown", 24'h1, 24'(shut));
      drive_cs(1'b0);
      wait_cyc(6);
      check_val("busy_restart", 24'h1, 24'(pin));
      // Chip select toggled within one conversion
      drive_cs(1'b1);
      wait_cyc(2);
      drive_cs(1'b0);
      wait_cyc(60);
      check_val("latched_busy", 24'h1, 24'(pin));
      check_val("no_restart", 24'h0, 24'(run));
      summarize();
   end
endmodule // adcr_tb_top
`default_nettype wire
